// >>> pkg/adc_ctl_pkg.sv
// Constants, register map and types shared by the converter control block.
package adc_ctl_pkg;

    // ***********************************************************************
    // Register byte offsets on the Avalon-MM slave.
    // ***********************************************************************
    localparam logic [4:0] OFF_MUX    = 5'h00;
    localparam logic [4:0] OFF_CTRL   = 5'h04;
    localparam logic [4:0] OFF_CTRLB  = 5'h08;
    localparam logic [4:0] OFF_RES_LO = 5'h0c;
    localparam logic [4:0] OFF_RES_HI = 5'h10;

    // ***********************************************************************
    // Field positions and reset values.
    // ***********************************************************************
    localparam int MUX_LEFT_BIT   = 5;
    localparam int CTRL_ON_BIT    = 7;
    localparam int CTRL_START_BIT = 6;
    localparam int CTRL_ATE_BIT   = 5;
    localparam int CTRL_FLAG_BIT  = 4;
    localparam int CTRL_IE_BIT    = 3;
    localparam int RESULT_W       = 10;
    localparam int LEFT_PAD_W     = 6;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [2:0] SRC_FREE    = 3'h0;

    // ***********************************************************************
    // Conversion lengths in converter clock cycles.
    // ***********************************************************************
    localparam logic [4:0] CONV_CYCLES_NORMAL = 5'd13;
    localparam logic [4:0] CONV_CYCLES_FIRST  = 5'd25;

    // ***********************************************************************
    // Channel codes and analog selector encodings.
    // ***********************************************************************
    localparam logic [1:0] CH_GRP_SINGLE = 2'b00;
    localparam logic [2:0] CH_GRP_DIFF1  = 3'b100;
    localparam logic [4:0] CH_DIFF2_LAST = 5'h1d;
    localparam logic [4:0] CH_DIFF2_LO   = 5'h18;
    localparam logic [4:0] CH_BANDGAP    = 5'h1e;
    localparam logic [3:0] POS_BANDGAP   = 4'h8;
    localparam logic [3:0] POS_GROUND    = 4'h9;
    localparam logic [1:0] NEG_NONE      = 2'h0;
    localparam logic [1:0] NEG_IN1       = 2'h1;
    localparam logic [1:0] NEG_IN2       = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_e;

    // Divide ratio of the converter clock for each prescaler code.
    function automatic logic [7:0] div_ratio(input logic [2:0] sel);
        logic [7:0] r;
        r = 8'h02;
        if (sel > 3'h1)
        begin
            r = 8'h01 << sel;
        end
        return r;
    endfunction

endpackage

// >>> pkg/clk_div_if.sv
// Link between the control logic and its converter clock prescaler.
`timescale 1ns/10ps
interface clk_div_if;
    logic       run;
    logic [2:0] sel;
    logic       tick;

    modport ctl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface

// >>> hw/adc_clk_div.sv
// Prescaler that forms the converter clock tick from the system clock.
`timescale 1ns/10ps
module adc_clk_div
    import adc_ctl_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Control side.
    clk_div_if.div   dv
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    // Count one ratio per tick; held at zero while the converter is off.
    always_comb
    begin
        cnt_d  = 8'h00;
        tick_d = 1'b0;
        if (dv.run)
        begin
            if (cnt_q >= div_ratio(dv.sel) - 8'h01)
            begin
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    // Registers of the prescaler.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;

endmodule

// >>> hw/adc_conversion_control.sv
// Conversion control of a 10-bit successive-approximation converter.
//
// What this block does
// - Left-justify bit set shows result left-justified, else right-justified.
// - Justification change shows on result registers immediately.
// - Codes 0-7 pick single inputs; 11110 bandgap, 11111 ground.
// - Codes 10000-10111 pair input n with 1; 11000-11101 with 2.
// - Channel writes during a conversion apply only after it completes.
// - Converter on bit powers the converter up; clearing it turns off.
// - Clearing the on bit during a conversion aborts it.
// - First conversion after enabling takes 25 cycles, else 13.
// - Start bit reads one while busy; writing zero does nothing.
// - Auto-trigger starts a conversion on a rising trigger edge while idle.
// - Done flag sets when a conversion ends; the result is stored unless locked.
// - Interrupt asks only while flag, enable and global enable hold.
// - Taking the interrupt vector clears the done flag.
// - Writing one clears the done flag, writing zero leaves it.
// - Prescaler codes give ratios 2,2,4,8,16,32,64,128.
// - Trigger source field picks the event; zero means free running.
// - After low byte read, result holds until the high byte read.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module adc_conversion_control
    import adc_ctl_pkg::*;
#(
    parameter int TRIG_N = 7
)
(
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // Avalon-MM slave.
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Processor side.
    input  wire logic              global_irq_en,
    input  wire logic              irq_ack,
    output logic                   irq_q,
    input  wire logic [TRIG_N-1:0] trig_in,
    // Analog front end.
    input  wire logic [9:0]        afe_result,
    output logic                   afe_power_q,
    output logic                   afe_start_q,
    output logic                   afe_step_q,
    output logic                   afe_diff_q,
    output logic      [3:0]        afe_pos_sel_q,
    output logic      [1:0]        afe_neg_sel_q
);

    // ***********************************************************************
    // Prescaler.
    // ***********************************************************************
    clk_div_if   cdv ();
    adc_clk_div  u_div (.ref_clk(ref_clk), .rstn(rstn), .dv(cdv.div));

    // ***********************************************************************
    // State and bus decode.
    // ***********************************************************************
    logic [7:0]    mux_q, mux_d;
    logic          en_q, en_d, ate_q, ate_d, flag_q, flag_d, ie_q, ie_d;
    logic [2:0]    ps_q, ps_d, src_q, src_d;
    logic [4:0]    ch_q, ch_d, cnt_q, cnt_d;
    logic [9:0]    res_q, res_d;
    logic          first_q, first_d, lock_q, lock_d, trig_prev_q;
    logic          wait_q, wait_d, irq_d, start_d, step_d;
    logic [31:0]   rdata_q, rdata_d;
    conv_state_e   st_q, st_d;
    logic          wr_acc, rd_acc, wr_ctrl, trig_sel, trig_edge;
    logic          sw_start, done, free_run, launch;
    logic [7:0]    wdat, res_lo, res_hi;
    logic [4:0]    len;
    logic          dec_diff;
    logic [3:0]    dec_pos;
    logic [1:0]    dec_neg;

    assign wdat     = avs_writedata[7:0];
    assign wr_acc   = avs_write && !wait_q && avs_byteenable[0];
    assign rd_acc   = avs_read && !wait_q;
    assign wr_ctrl  = wr_acc && avs_address == OFF_CTRL;
    assign cdv.run  = en_q;
    assign cdv.sel  = ps_q;

    // Justification is applied at read time, so the bit acts at once.
    assign res_hi = mux_q[MUX_LEFT_BIT] ? res_q[9:2]
                  : {{LEFT_PAD_W{1'b0}}, res_q[9:8]};
    assign res_lo = mux_q[MUX_LEFT_BIT] ? {res_q[1:0], {LEFT_PAD_W{1'b0}}}
                  : res_q[7:0];

    // Trigger selection; code zero has no edge of its own.
    assign trig_sel  = (src_q == SRC_FREE) ? 1'b0 : trig_in[src_q - 3'h1];
    assign trig_edge = ate_q && en_q && trig_sel && !trig_prev_q;
    assign free_run  = ate_q && src_q == SRC_FREE;
    assign sw_start  = wr_ctrl && wdat[CTRL_START_BIT]
                     && wdat[CTRL_ON_BIT];
    assign len       = first_q ? CONV_CYCLES_FIRST : CONV_CYCLES_NORMAL;
    // An off write in the same cycle cancels both; the bus write is decoded
    // here, not en_d, so no loop runs back through the sequencer.
    assign done      = st_q == ST_CONV && cdv.tick && cnt_q == len - 5'd1
                     && !(wr_ctrl && !wdat[CTRL_ON_BIT]);
    assign launch    = st_q == ST_IDLE && (sw_start
                     || (trig_edge && !(wr_ctrl && !wdat[CTRL_ON_BIT])));

    // Channel code to analog selector decode.
    always_comb
    begin
        dec_diff = 1'b0;
        dec_pos  = POS_GROUND;
        dec_neg  = NEG_NONE;
        if (ch_d[4:3] == CH_GRP_SINGLE)
        begin
            dec_pos = {1'b0, ch_d[2:0]};
        end
        else if (ch_d[4:2] == CH_GRP_DIFF1 || ch_d[4:2] == 3'b101)
        begin
            dec_diff = 1'b1;
            dec_pos  = {1'b0, ch_d[2:0]};
            dec_neg  = NEG_IN1;
        end
        else if (ch_d >= CH_DIFF2_LO && ch_d <= CH_DIFF2_LAST)
        begin
            dec_diff = 1'b1;
            dec_pos  = {1'b0, ch_d[2:0]};
            dec_neg  = NEG_IN2;
        end
        else if (ch_d == CH_BANDGAP)
        begin
            dec_pos = POS_BANDGAP;
        end
    end

    // Next values of registers, conversion sequencer and bus answer.
    always_comb
    begin
        mux_d   = mux_q;
        en_d    = en_q;
        ate_d   = ate_q;
        ie_d    = ie_q;
        ps_d    = ps_q;
        src_d   = src_q;
        if (wr_acc && avs_address == OFF_MUX)
        begin
            mux_d = wdat;
        end
        if (wr_ctrl)
        begin
            en_d  = wdat[CTRL_ON_BIT];
            ate_d = wdat[CTRL_ATE_BIT];
            ie_d  = wdat[CTRL_IE_BIT];
            ps_d  = wdat[2:0];
        end
        if (wr_acc && avs_address == OFF_CTRLB)
        begin
            src_d = wdat[2:0];
        end
        st_d    = st_q;
        cnt_d   = cnt_q;
        ch_d    = ch_q;
        start_d = 1'b0;
        if (!en_d)
        begin
            st_d  = ST_IDLE;
            cnt_d = 5'd0;
        end
        else if (launch)
        begin
            st_d    = ST_CONV;
            cnt_d   = 5'd0;
            ch_d    = mux_d[4:0];
            start_d = 1'b1;
        end
        else if (st_q == ST_CONV && cdv.tick)
        begin
            cnt_d = cnt_q + 5'd1;
            if (done)
            begin
                cnt_d = 5'd0;
                ch_d  = mux_d[4:0];
                if (free_run)
                begin
                    start_d = 1'b1;
                end
                else
                begin
                    st_d = ST_IDLE;
                end
            end
        end
        first_d = !en_q || (first_q && !done);
        // A finishing conversion wins over a clear in the same cycle.
        flag_d  = flag_q;
        if ((wr_ctrl && wdat[CTRL_FLAG_BIT]) || irq_ack)
        begin
            flag_d = 1'b0;
        end
        if (done)
        begin
            flag_d = 1'b1;
        end
        // A locked result drops the new sample rather than tear the pair.
        res_d  = (done && !lock_q) ? afe_result : res_q;
        lock_d = lock_q;
        if (rd_acc && avs_address == OFF_RES_LO)
        begin
            lock_d = 1'b1;
        end
        else if (rd_acc && avs_address == OFF_RES_HI)
        begin
            lock_d = 1'b0;
        end
        irq_d  = flag_q && ie_q && global_irq_en;
        step_d = st_q == ST_CONV && cdv.tick;
        // One wait cycle per access; read data are fetched in it.
        wait_d  = !(wait_q && (avs_read || avs_write));
        rdata_d = rdata_q;
        if (wait_q && avs_read)
        begin
            unique case (avs_address)
                OFF_MUX:    rdata_d = {24'h0, mux_q};
                OFF_CTRL:   rdata_d = {24'h0, en_q, st_q == ST_CONV,
                                       ate_q, flag_q, ie_q, ps_q};
                OFF_CTRLB:  rdata_d = {29'h0, src_q};
                OFF_RES_LO: rdata_d = {24'h0, res_lo};
                OFF_RES_HI: rdata_d = {24'h0, res_hi};
                default:    rdata_d = 32'h0;
            endcase
        end
    end

    // Registers.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mux_q         <= REG_RESET;
            en_q          <= 1'b0;
            ate_q         <= 1'b0;
            flag_q        <= 1'b0;
            ie_q          <= 1'b0;
            ps_q          <= 3'h0;
            src_q         <= SRC_FREE;
            ch_q          <= 5'h00;
            cnt_q         <= 5'd0;
            res_q         <= 10'h000;
            first_q       <= 1'b1;
            lock_q        <= 1'b0;
            trig_prev_q   <= 1'b0;
            st_q          <= ST_IDLE;
            wait_q        <= 1'b1;
            rdata_q       <= 32'h0;
            irq_q         <= 1'b0;
            afe_start_q   <= 1'b0;
            afe_step_q    <= 1'b0;
            afe_diff_q    <= 1'b0;
            afe_pos_sel_q <= 4'h0;
            afe_neg_sel_q <= NEG_NONE;
        end
        else
        begin
            mux_q         <= mux_d;
            en_q          <= en_d;
            ate_q         <= ate_d;
            flag_q        <= flag_d;
            ie_q          <= ie_d;
            ps_q          <= ps_d;
            src_q         <= src_d;
            ch_q          <= ch_d;
            cnt_q         <= cnt_d;
            res_q         <= res_d;
            first_q       <= first_d;
            lock_q        <= lock_d;
            trig_prev_q   <= trig_sel;
            st_q          <= st_d;
            wait_q        <= wait_d;
            rdata_q       <= rdata_d;
            irq_q         <= irq_d;
            afe_start_q   <= start_d;
            afe_step_q    <= step_d;
            afe_diff_q    <= dec_diff;
            afe_pos_sel_q <= dec_pos;
            afe_neg_sel_q <= dec_neg;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign afe_power_q     = en_q;

    // ***********************************************************************
    // Assertions.
    // ***********************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_off_is_idle:   assert property (!en_q |-> st_q == ST_IDLE)
        else $error("converter off but not idle");
    chk_flag_on_done:  assert property (done |=> flag_q)
        else $error("done flag not set after conversion");
    chk_irq_gating:    assert property (irq_q |->
        $past(flag_q) && $past(ie_q) && $past(global_irq_en))
        else $error("interrupt without flag and enables");
    chk_channel_hold:  assert property (st_q == ST_CONV &&
        $past(st_q) == ST_CONV && !$past(done) |-> $stable(ch_q))
        else $error("channel changed mid conversion");
    chk_write1_clear:  assert property (wr_ctrl && wdat[CTRL_FLAG_BIT]
        && !done |=> !flag_q)
        else $error("write one did not clear done flag");
    chk_ack_clear:     assert property (irq_ack && !done |=> !flag_q)
        else $error("vector did not clear done flag");
    chk_zero_start:    assert property (st_q == ST_IDLE && wr_ctrl &&
        !wdat[CTRL_START_BIT] && !ate_q && !ate_d |=> st_q == ST_IDLE)
        else $error("writing zero to start started a conversion");
    chk_lock_hold:     assert property (lock_q && $past(lock_q) |->
        $stable(res_q))
        else $error("result changed while low byte read");
    chk_first_len:     assert property (done && first_q |->
        cnt_q == CONV_CYCLES_FIRST - 5'd1)
        else $error("first conversion length wrong");
    chk_hi_justify:    assert property (rd_acc && avs_address == OFF_RES_HI
        && mux_q[MUX_LEFT_BIT] && $stable(mux_q) && $stable(res_q)
        |-> avs_readdata[7:0] == res_q[9:2])
        else $error("left justified high byte wrong");

    cov_first_conv:    cover property (done && first_q);
    cov_free_run:      cover property (done && free_run);
    cov_abort:         cover property (st_q == ST_CONV && !en_d);
    cov_trigger:       cover property (trig_edge && st_q == ST_IDLE);

endmodule

// >>> tb/afe_model.sv
// Behavioural model of the analog front end behind the control block.
`timescale 1ns/10ps
module afe_model
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Control side.
    input  wire logic       power,
    input  wire logic       start,
    input  wire logic       step,
    input  wire logic       diff,
    input  wire logic [3:0] pos,
    input  wire logic [1:0] neg,
    // Result and observations.
    output logic      [9:0] result,
    output int              steps,
    output int              gap,
    output int              starts
);
    // ***********************************************************************
    // Conversion core.
    // ***********************************************************************
    logic [9:0] code_q;
    int         now_q;
    int         last_q;

    // The code is taken at the first step, once the selector has settled.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            code_q <= 10'h000;
            now_q  <= 0;
            last_q <= 0;
            steps  <= 0;
            gap    <= 0;
            starts <= 0;
        end
        else
        begin
            now_q <= now_q + 1;
            if (step)
            begin
                if (steps == 0)
                begin
                    code_q <= {diff, neg, pos, 3'h5};
                end
                steps  <= steps + 1;
                gap    <= now_q - last_q;
                last_q <= now_q;
            end
            // In free running the last step and the next start coincide,
            // so the start comes last and restarts the count.
            if (start)
            begin
                steps  <= 0;
                starts <= starts + 1;
            end
        end
    end

    // An unpowered core shows no stale value, so the output is inverted.
    assign result = power ? code_q : ~code_q;
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/10ps
module tb_top
    import adc_ctl_pkg::*;
;
    // ***********************************************************************
    // Signals.
    // ***********************************************************************
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        global_irq_en = 1'b0;
    logic        irq_ack = 1'b0;
    logic        irq_q;
    logic [6:0]  trig_in = 7'h00;
    logic [9:0]  afe_result;
    logic        afe_power_q, afe_start_q, afe_step_q, afe_diff_q;
    logic [3:0]  afe_pos_sel_q;
    logic [1:0]  afe_neg_sel_q;
    int          steps, gap, starts, miscompares, checked, s0;
    logic [7:0]  d, lo, hi;
    logic [4:0]  tbl [9] = '{5'h00, 5'h07, 5'h08, 5'h10, 5'h17, 5'h18,
                             5'h1d, 5'h1e, 5'h1f};
    logic [9:0]  r;

    adc_conversion_control dut (.ref_clk(ref_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .global_irq_en(global_irq_en),
        .irq_ack(irq_ack), .irq_q(irq_q), .trig_in(trig_in),
        .afe_result(afe_result), .afe_power_q(afe_power_q),
        .afe_start_q(afe_start_q), .afe_step_q(afe_step_q),
        .afe_diff_q(afe_diff_q), .afe_pos_sel_q(afe_pos_sel_q),
        .afe_neg_sel_q(afe_neg_sel_q));

    afe_model afe (.ref_clk(ref_clk), .rstn(rstn), .power(afe_power_q),
        .start(afe_start_q), .step(afe_step_q), .diff(afe_diff_q),
        .pos(afe_pos_sel_q), .neg(afe_neg_sel_q), .result(afe_result),
        .steps(steps), .gap(gap), .starts(starts));

    // The 250 MHz system clock.
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ***********************************************************************
    // Helpers.
    // ***********************************************************************
    task automatic end_sim();
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low.
    task automatic bus(input logic [4:0] a, input logic wr_en,
                       input logic [7:0] wd, output logic [7:0] rd_d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_write     <= wr_en;
        avs_read      <= !wr_en;
        avs_writedata <= {24'h0, wd};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            end_sim();
        end
        rd_d = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] wd);
        logic [7:0] unused;
        bus(a, 1'b1, wd, unused);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] rd_d);
        bus(a, 1'b0, 8'h00, rd_d);
    endtask

    // Polls the done flag; a long prescaler needs over 500 polls.
    task automatic wait_done();
        logic [7:0] v;
        int         n;
        n = 0;
        v = 8'h00;
        while (v[CTRL_FLAG_BIT] !== 1'b1 && n < 1000)
        begin
            rd(OFF_CTRL, v);
            n++;
        end
        if (n >= 1000)
        begin
            miscompares++;
            end_sim();
        end
    endtask

    // Expected selector as {diff, negative, positive} for a channel code.
    function automatic logic [6:0] exp_sel(input logic [4:0] c);
        if (c < 5'h08)
            return {3'b000, 1'b0, c[2:0]};
        else if (c < 5'h10 || c == 5'h1f)
            return {3'b000, 4'h9};
        else if (c < 5'h18)
            return {3'b101, 1'b0, c[2:0]};
        else if (c < 5'h1e)
            return {3'b110, 1'b0, c[2:0]};
        return {3'b000, 4'h8};
    endfunction

    function automatic int ratio(input int ps);
        return (ps < 2) ? 2 : (1 << ps);
    endfunction

    // ***********************************************************************
    // Main sequence.
    // ***********************************************************************
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        // Reset values, unmapped place included.
        for (int a = 0; a < 6; a++)
        begin
            rd(5'(a * 4), d);
            compare(d, 8'h00);
        end
        // First conversion after enabling, right justified.
        wr(OFF_MUX, 8'h03);
        wr(OFF_CTRL, 8'hc0);
        rd(OFF_CTRL, d);
        compare(d[CTRL_START_BIT], 1'b1);
        compare(afe_power_q, 1'b1);
        wait_done();
        compare({afe_diff_q, afe_neg_sel_q, afe_pos_sel_q}, exp_sel(5'h03));
        compare(steps, 25);
        rd(OFF_CTRL, d);
        compare(d, 8'h90);
        r = {exp_sel(5'h03), 3'h5};
        rd(OFF_RES_LO, lo);
        rd(OFF_RES_HI, hi);
        compare({hi, lo}, {6'h00, r});
        // Left justify shows at once on the stored result.
        wr(OFF_MUX, 8'h23);
        rd(OFF_RES_LO, lo);
        rd(OFF_RES_HI, hi);
        compare({hi, lo}, {r, 6'h00});
        wr(OFF_MUX, 8'h03);
        // Flag: zero write and masked write keep it, a one clears it.
        wr(OFF_CTRL, 8'h80);
        avs_byteenable <= 4'he;
        wr(OFF_CTRL, 8'h10);
        avs_byteenable <= 4'hf;
        rd(OFF_CTRL, d);
        compare(d, 8'h90);
        wr(OFF_CTRL, 8'h90);
        rd(OFF_CTRL, d);
        compare(d, 8'h80);
        // Every channel group and prescaler code; mid-run channel writes.
        for (int i = 0; i < 9; i++)
        begin
            wr(OFF_MUX, {3'h0, tbl[i]});
            wr(OFF_CTRL, 8'hd0 | 8'(i % 8));
            wr(OFF_MUX, {3'h0, tbl[(i + 1) % 9]});
            compare({afe_diff_q, afe_neg_sel_q, afe_pos_sel_q},
                    exp_sel(tbl[i]));
            wait_done();
            compare(steps, 13);
            compare(gap, ratio(i % 8));
            rd(OFF_RES_LO, lo);
            rd(OFF_RES_HI, hi);
            compare({hi, lo}, {6'h00, exp_sel(tbl[i]), 3'h5});
        end
        // Result stays locked between the low and high byte reads.
        rd(OFF_RES_LO, lo);
        wr(OFF_MUX, 8'h05);
        wr(OFF_CTRL, 8'hd0);
        wait_done();
        rd(OFF_RES_HI, hi);
        compare({hi, lo}, {6'h00, exp_sel(tbl[8]), 3'h5});
        // Abort by clearing the on bit, then a fresh first conversion.
        wr(OFF_CTRL, 8'hd7);
        repeat (20) @(posedge ref_clk);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_CTRL, d);
        compare(d, 8'h00);
        compare(afe_power_q, 1'b0);
        wr(OFF_CTRL, 8'hc0);
        wait_done();
        compare(steps, 25);
        // Interrupt needs flag, enable and the global enable.
        wr(OFF_CTRL, 8'hd8);
        wait_done();
        repeat (3) @(posedge ref_clk);
        compare(irq_q, 1'b0);
        global_irq_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        compare(irq_q, 1'b1);
        irq_ack <= 1'b1;
        @(posedge ref_clk);
        irq_ack <= 1'b0;
        repeat (3) @(posedge ref_clk);
        compare(irq_q, 1'b0);
        rd(OFF_CTRL, d);
        compare(d[CTRL_FLAG_BIT], 1'b0);
        // Auto trigger on source 3, then free running.
        wr(OFF_CTRLB, 8'h03);
        wr(OFF_CTRL, 8'hb0);
        s0 = starts;
        trig_in <= 7'h04;
        wait_done();
        trig_in <= 7'h00;
        compare(starts - s0, 1);
        wr(OFF_CTRLB, 8'h00);
        s0 = starts;
        wr(OFF_CTRL, 8'hf0);
        repeat (200) @(posedge ref_clk);
        compare(starts - s0 >= 4, 1'b1);
        wr(OFF_CTRL, 8'h00);
        end_sim();
    end
endmodule
